/* hdl/pp_dma.sv */
// Parallel port DMA control: registers, DMA and chaining, external strobe engine, data FIFO
`timescale 1ns/1ps
`default_nettype none
`include "pp_dma_params.svh"

// ***********************
// Data FIFO
// ***********************
module stream_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [W-1:0]     in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [W-1:0]          out_data,
  input  wire logic             out_ready,
  output logic [$clog2(D):0]    level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rp_reg];
  assign level     = cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || flush) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // stream_fifo

// ***********************
// Port DMA top
// ***********************
// How it works
// - Busy bit 17 high for whole word transfer
// - Busy rises two cycles after data ready
// - Read-only bit 18 shows chain load
// - Bit 30 enables descriptor chaining
// - Bit 31 three-states all port pins
// - Duration default only in user boot
// - Transmit buffer feeds shift register; DMA refills
// - Receive buffer captures word; DMA stores it
// - Status register reports receive buffer fill
// - 19-bit internal word index
// - 16-bit internal step per word
// - 16-bit internal words remaining
// - 24-bit external address index
// - External step is plus one, zero, minus one
// - 24-bit external units remaining
// - Chain pointer: address bits, select bit 19
// - Select bit: interrupt per block or chain
// - Zero chain address ends the chain
// - Port disable flushes; strobe finishes; two-cycle start
// - DMA disable: pending finishes, no new data requests; a chain load in progress keeps fetching
// - Direction bit: 0 read, 1 write
// - Width bit: 0 byte, 1 halfword
module pp_dma #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_WORDS
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic                 boot_user_mode,
  input  wire pp_dma_pkg::iop_req_t iop_req,
  output logic [31:0]               iop_rdata,
  output logic                      iop_rvalid,
  output pp_dma_pkg::mem_req_t      mem_req,
  input  wire logic                 mem_ack,
  input  wire logic [31:0]          mem_rdata,
  output pp_dma_pkg::pins_t         pins,
  input  wire logic [15:0]          ad_in,
  output logic                      dma_irq
);
  import pp_dma_pkg::*;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  function automatic logic [23:0] ext_step(input logic [1:0] m);
    return (m == 2'h1) ? 24'h000001 : (m == 2'h3) ? 24'hFFFFFF : 24'h000000;
  endfunction

  // ***********************
  // Registers
  // ***********************
  logic        port_enable, port_dma_enable, transfer_direction, wide_data_select;
  logic        chain_enable, pin_tristate, dur_init_done;
  logic [4:0]  cycle_duration;
  logic [31:0] transmit_buffer;
  logic [23:0] external_index, external_count;
  logic [1:0]  external_modifier;
  logic [18:0] internal_index;
  logic [15:0] internal_modifier, internal_count;
  logic [19:0] chain_pointer;
  logic        chain_load_active, blk_live, rx_armed;
  logic [2:0]  tcb_idx;
  logic [18:0] tcb_base;
  logic [1:0]  launch_pipe;
  eng_state_t  state;
  logic [4:0]  phase_cnt;
  logic [1:0]  unit_cnt;
  logic [31:0] shift_reg;
  mem_req_t    mem_reg;
  pins_t       pins_reg;

  // ***********************
  // Decode
  // ***********************
  wire wr_ctl   = iop_req.wr && (iop_req.addr == `OFS_PORT_CONTROL);
  wire wr_tx    = iop_req.wr && (iop_req.addr == `OFS_TRANSMIT_BUFFER);
  wire rd_rx    = iop_req.rd && (iop_req.addr == `OFS_RECEIVE_BUFFER);
  wire [31:0] wd = iop_req.wdata;
  wire new_en   = wd[`BIT_PORT_ENABLE];
  wire flush    = wr_ctl && port_enable && !new_en;
  wire eng_idle = (state == E_IDLE);
  wire unit_end = (state == E_DATA) && (phase_cnt == 5'h00);
  wire word_end = unit_end && (unit_cnt == 2'h0);
  wire [4:0] dur_eff = (cycle_duration < `DUR_MIN) ? `DUR_MIN : cycle_duration;
  wire [18:0] cp_addr = chain_pointer[18:0];
  wire chain_more = chain_enable && (cp_addr != 19'h0);

  // FIFO hookup: transmit side fills from core or DMA, receive side from the engine
  logic          f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [31:0]   f_in_data, f_out_data;
  logic [LW-1:0] f_level;
  wire dma_rd_ack = mem_ack && !mem_reg.we && !chain_load_active;
  wire dma_wr_ack = mem_ack && mem_reg.we;
  wire eng_load   = eng_idle && launch_pipe[0] && transfer_direction && f_out_valid;
  wire rx_pop_core = rd_rx && !port_dma_enable && f_out_valid;
  // Last unit joins the word on the same edge that pushes it
  wire [31:0] rx_word = wide_data_select ? {ad_in, shift_reg[31:16]}
                                         : {ad_in[7:0], shift_reg[31:8]};
  assign f_in_valid  = transfer_direction ? ((wr_tx && port_enable) || dma_rd_ack)
                                          : (word_end && pins_reg.wr_n);
  assign f_in_data   = transfer_direction ? (dma_rd_ack ? mem_rdata : wd) : rx_word;
  assign f_out_ready = transfer_direction ? eng_load : (rx_pop_core || dma_wr_ack);

  stream_fifo #(.W(32), .D(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .flush     (flush),
    .in_valid  (f_in_valid),
    .in_data   (f_in_data),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (f_out_ready),
    .level     (f_level)
  );

  wire fifo_full = !f_in_ready;
  wire [1:0] fifo_stat = fifo_full ? 2'h3 : (f_out_valid ? 2'h1 : 2'h0);

  // Engine start: transmit needs a word; receive needs room plus a reason to read
  wire rx_want = (port_dma_enable && external_count != 24'h0) || rx_armed;
  wire want    = port_enable && !pin_tristate &&
                 (transfer_direction ? f_out_valid : (f_in_ready && rx_want));
  wire start   = eng_idle && launch_pipe[0] && want;

  // ***********************
  // Control register
  // ***********************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      port_enable <= 1'b0;
      port_dma_enable <= 1'b0;
      transfer_direction <= 1'b0;
      wide_data_select <= 1'b0;
      chain_enable <= 1'b0;
      pin_tristate <= 1'b0;
      cycle_duration <= `DUR_RESET_OTHER_BOOT;
      dur_init_done <= 1'b0;
    end else if (wr_ctl) begin
      port_enable <= new_en;
      cycle_duration <= wd[`BIT_DUR_HI:`BIT_DUR_LO];
      wide_data_select <= wd[`BIT_WIDE_DATA];
      port_dma_enable <= wd[`BIT_PORT_DMA_ENABLE];
      transfer_direction <= wd[`BIT_TRANSFER_DIR];
      chain_enable <= wd[`BIT_CHAIN_ENABLE];
      pin_tristate <= wd[`BIT_PIN_TRISTATE];
      dur_init_done <= 1'b1;
    end else if (!dur_init_done) begin
      // Strap taken one edge after release, never under reset
      cycle_duration <= boot_user_mode ? `DUR_RESET_USER_BOOT : `DUR_RESET_OTHER_BOOT;
      dur_init_done <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) transmit_buffer <= 32'h0;
    else if (wr_tx) transmit_buffer <= wd;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || flush) begin
      rx_armed <= 1'b0;
    end else if ((rd_rx && port_enable) || (wr_ctl && new_en && wd[`BIT_PORT_DMA_ENABLE])) begin
      rx_armed <= 1'b1;
    end else if (start) begin
      rx_armed <= 1'b0;
    end
  end

  // ***********************
  // External strobe engine
  // ***********************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) launch_pipe <= 2'h0;
    else launch_pipe <= {launch_pipe[0], want && eng_idle && !launch_pipe[0]};
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= E_IDLE;
      phase_cnt <= 5'h00;
      unit_cnt <= 2'h0;
    end else begin
      case (state)
        E_IDLE: begin
          if (start) begin
            state <= E_ALE;
            phase_cnt <= `ALE_CYCLES - 5'h01;
          end
        end
        E_ALE: begin
          if (phase_cnt == 5'h00) begin
            state <= E_DATA;
            phase_cnt <= dur_eff - 5'h01;
            unit_cnt <= wide_data_select ? 2'h1 : 2'h3;
          end else begin
            phase_cnt <= phase_cnt - 5'h01;
          end
        end
        E_DATA: begin
          if (phase_cnt != 5'h00) begin
            phase_cnt <= phase_cnt - 5'h01;
          end else if (unit_cnt == 2'h0 || !port_enable) begin
            state <= E_IDLE;
          end else begin
            unit_cnt <= unit_cnt - 2'h1;
            phase_cnt <= dur_eff - 5'h01;
          end
        end
        default: state <= E_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      shift_reg <= 32'h0;
    end else if (eng_load) begin
      shift_reg <= f_out_data;
    end else if (unit_end) begin
      if (!pins_reg.wr_n) shift_reg <= wide_data_select ? {16'h0, shift_reg[31:16]}
                                                        : {8'h0, shift_reg[31:8]};
      else shift_reg <= rx_word;
    end
  end

  // Pins are registered images of the engine; strobe released on the last cycle of a unit
  pins_t pins_next;
  wire drive = !pin_tristate;
  wire in_ale = (state == E_ALE);
  wire strobe_on = (state == E_DATA) && (phase_cnt != 5'h00);
  always_comb begin
    pins_next.ale       = in_ale;
    pins_next.rd_n      = !(strobe_on && !transfer_direction);
    pins_next.wr_n      = !(strobe_on && transfer_direction);
    pins_next.ad_oe     = drive && (in_ale || (strobe_on && transfer_direction));
    pins_next.strobe_oe = drive;
    pins_next.ad_out    = in_ale ? external_index[15:0]
                        : (wide_data_select ? shift_reg[15:0] : {8'h00, shift_reg[7:0]});
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) pins_reg <= '{16'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    else pins_reg <= pins_next;
  end

  // ***********************
  // DMA parameters and chaining
  // ***********************
  wire mem_idle  = !mem_reg.req;
  wire dma_go    = port_enable && port_dma_enable && !chain_load_active;
  wire issue_tx  = dma_go && transfer_direction && internal_count != 16'h0 &&
                   f_level < LW'(FIFO_DEPTH - 1);
  wire issue_rx  = dma_go && !transfer_direction && internal_count != 16'h0 && f_out_valid;
  wire issue_dma = mem_idle && (issue_tx || issue_rx);
  wire issue_tcb = mem_idle && chain_load_active;
  wire blk_done  = blk_live && dma_go && internal_count == 16'h0 && mem_idle &&
                   (!transfer_direction || (!f_out_valid && eng_idle));
  wire tcb_ack   = mem_ack && chain_load_active;
  wire ext_step_en = unit_end && port_dma_enable;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mem_reg <= '0;
    end else if (mem_ack) begin
      mem_reg.req <= 1'b0;
    end else if (issue_tcb) begin
      mem_reg <= '{1'b1, 1'b0, tcb_base + {16'h0, tcb_idx}, 32'h0};
    end else if (issue_dma) begin
      mem_reg <= '{1'b1, !transfer_direction, internal_index, f_out_data};
    end
  end

  // Descriptor words in memory order: index, modifier, count, pointer, ext index, ext mod, ext count
  wire ld = tcb_ack;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      internal_index <= 19'h0;
      internal_modifier <= 16'h0;
      internal_count <= 16'h0;
      chain_pointer <= 20'h0;
    end else begin
      if (iop_req.wr && iop_req.addr == `OFS_INTERNAL_INDEX) internal_index <= wd[18:0];
      else if (ld && tcb_idx == 3'h0) internal_index <= mem_rdata[18:0];
      else if (issue_dma) internal_index <= internal_index + {3'h0, internal_modifier};
      if (iop_req.wr && iop_req.addr == `OFS_INTERNAL_MODIFIER) internal_modifier <= wd[15:0];
      else if (ld && tcb_idx == 3'h1) internal_modifier <= mem_rdata[15:0];
      if (iop_req.wr && iop_req.addr == `OFS_INTERNAL_COUNT) internal_count <= wd[15:0];
      else if (ld && tcb_idx == 3'h2) internal_count <= mem_rdata[15:0];
      else if (issue_dma) internal_count <= internal_count - 16'h1;
      if (iop_req.wr && iop_req.addr == `OFS_CHAIN_POINTER) chain_pointer <= wd[19:0];
      else if (ld && tcb_idx == 3'h3) chain_pointer <= mem_rdata[19:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      external_index <= 24'h0;
      external_modifier <= 2'h0;
      external_count <= 24'h0;
    end else begin
      if (iop_req.wr && iop_req.addr == `OFS_EXTERNAL_INDEX) external_index <= wd[23:0];
      else if (ld && tcb_idx == 3'h4) external_index <= mem_rdata[23:0];
      else if (ext_step_en) external_index <= external_index + ext_step(external_modifier);
      if (iop_req.wr && iop_req.addr == `OFS_EXTERNAL_MODIFIER) external_modifier <= wd[1:0];
      else if (ld && tcb_idx == 3'h5) external_modifier <= mem_rdata[1:0];
      if (iop_req.wr && iop_req.addr == `OFS_EXTERNAL_COUNT) external_count <= wd[23:0];
      else if (ld && tcb_idx == 3'h6) external_count <= mem_rdata[23:0];
      else if (ext_step_en && external_count != 24'h0) external_count <= external_count - 24'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      chain_load_active <= 1'b0;
      tcb_idx <= 3'h0;
      tcb_base <= 19'h0;
      blk_live <= 1'b0;
      dma_irq <= 1'b0;
    end else begin
      dma_irq <= blk_done && (chain_pointer[`BIT_CHAIN_IRQ_SELECT] || !chain_more);
      if (blk_done) begin
        blk_live <= 1'b0;
        chain_load_active <= chain_more;
        tcb_idx <= 3'h0;
        // Base held apart: the pointer word itself is reloaded mid-fetch
        tcb_base <= cp_addr;
      end else if (tcb_ack) begin
        tcb_idx <= tcb_idx + 3'h1;
        if (tcb_idx == `TCB_WORDS - 3'h1) begin
          chain_load_active <= 1'b0;
          blk_live <= 1'b1;
        end
      end else if (dma_go && internal_count != 16'h0) begin
        blk_live <= 1'b1;
      end
    end
  end

  // ***********************
  // Register read path
  // ***********************
  logic [31:0] ctl_word, rd_mux;
  always_comb begin
    ctl_word = 32'h0;
    ctl_word[`BIT_PORT_ENABLE] = port_enable;
    ctl_word[`BIT_DUR_HI:`BIT_DUR_LO] = cycle_duration;
    ctl_word[`BIT_WIDE_DATA] = wide_data_select;
    ctl_word[`BIT_PORT_DMA_ENABLE] = port_dma_enable;
    ctl_word[`BIT_TRANSFER_DIR] = transfer_direction;
    ctl_word[`BIT_FIFO_STAT_HI:`BIT_FIFO_STAT_LO] = fifo_stat;
    ctl_word[`BIT_DMA_ACTIVE] = !mem_idle && !chain_load_active;
    ctl_word[`BIT_EXT_BUS_BUSY] = !eng_idle;
    ctl_word[`BIT_CHAIN_LOAD_ACTIVE] = chain_load_active;
    ctl_word[`BIT_CHAIN_ENABLE] = chain_enable;
    ctl_word[`BIT_PIN_TRISTATE] = pin_tristate;
  end

  wire [15:0] ra = iop_req.addr;
  assign rd_mux =
      (ra == `OFS_PORT_CONTROL)      ? ctl_word :
      (ra == `OFS_TRANSMIT_BUFFER)   ? transmit_buffer :
      (ra == `OFS_RECEIVE_BUFFER)    ? (f_out_valid ? f_out_data : 32'h0) :
      (ra == `OFS_EXTERNAL_INDEX)    ? {8'h0, external_index} :
      (ra == `OFS_EXTERNAL_MODIFIER) ? {30'h0, external_modifier} :
      (ra == `OFS_EXTERNAL_COUNT)    ? {8'h0, external_count} :
      (ra == `OFS_INTERNAL_INDEX)    ? {13'h0, internal_index} :
      (ra == `OFS_INTERNAL_MODIFIER) ? {16'h0, internal_modifier} :
      (ra == `OFS_INTERNAL_COUNT)    ? {16'h0, internal_count} :
      (ra == `OFS_CHAIN_POINTER)     ? {12'h0, chain_pointer} :
      (ra == `OFS_PORT_STATUS)       ? {30'h0, fifo_stat} :
                                       32'h0;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      iop_rdata <= 32'h0;
      iop_rvalid <= 1'b0;
    end else begin
      iop_rvalid <= iop_req.rd;
      if (iop_req.rd) iop_rdata <= rd_mux;
    end
  end

  assign mem_req = mem_reg;
  assign pins = pins_reg;
endmodule // pp_dma
`default_nettype wire

/* hdl/pp_dma_params.svh */
// Register offsets, field positions, reset values and timing counts of the port DMA block
`ifndef PP_DMA_PARAMS_SVH
`define PP_DMA_PARAMS_SVH

// ***********************
// Register offsets
// ***********************
`define OFS_PORT_CONTROL      16'h1800
`define OFS_TRANSMIT_BUFFER   16'h1808
`define OFS_RECEIVE_BUFFER    16'h1809
`define OFS_EXTERNAL_INDEX    16'h1810
`define OFS_EXTERNAL_MODIFIER 16'h1811
`define OFS_EXTERNAL_COUNT    16'h1812
`define OFS_INTERNAL_INDEX    16'h1818
`define OFS_INTERNAL_MODIFIER 16'h1819
`define OFS_INTERNAL_COUNT    16'h181A
`define OFS_CHAIN_POINTER     16'h181B
`define OFS_PORT_STATUS       16'h1830

// ***********************
// Control and status bit positions
// ***********************
`define BIT_PORT_ENABLE       0
`define BIT_DUR_LO            1
`define BIT_DUR_HI            5
`define BIT_WIDE_DATA         7
`define BIT_PORT_DMA_ENABLE   8
`define BIT_TRANSFER_DIR      9
`define BIT_FIFO_STAT_LO      10
`define BIT_FIFO_STAT_HI      11
`define BIT_DMA_ACTIVE        16
`define BIT_EXT_BUS_BUSY      17
`define BIT_CHAIN_LOAD_ACTIVE 18
`define BIT_CHAIN_ENABLE      30
`define BIT_PIN_TRISTATE      31
`define BIT_CHAIN_IRQ_SELECT  19
`define BIT_RX_STAT_LO        0
`define BIT_RX_STAT_HI        1

// ***********************
// Reset values and timing
// ***********************
`define DUR_RESET_USER_BOOT   5'h17
`define DUR_RESET_OTHER_BOOT  5'h00
`define DUR_MIN               5'h02
`define ALE_CYCLES            5'h03
`define START_DELAY_CYCLES    2
`define TCB_WORDS             3'h7
`define FIFO_DEPTH_WORDS      16

`endif

/* hdl/pp_dma_pkg.sv */
// Types shared by the port DMA block and its users
package pp_dma_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } iop_req_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [18:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [15:0] ad_out;
    logic        ad_oe;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    logic        strobe_oe;
  } pins_t;

  typedef enum {E_IDLE, E_ALE, E_DATA} eng_state_t;

endpackage

/* verif/pp_dma_properties.sv */
// Concurrent checks on the port DMA block's ports
`timescale 1ns/1ps
`default_nettype none
module pp_dma_checker (
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire pp_dma_pkg::iop_req_t iop_req,
  input wire logic                 iop_rvalid,
  input wire pp_dma_pkg::mem_req_t mem_req,
  input wire logic                 mem_ack,
  input wire pp_dma_pkg::pins_t    pins,
  input wire logic                 dma_irq
);
  import pp_dma_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // *****
  // Pin, read answer, memory request and interrupt checks
  // *****
  sequence ale_burst;
    pins.ale [*3] ##1 !pins.ale;
  endsequence
  a_ale_three_cycles: assert property ($rose(pins.ale) |-> ale_burst)
    else $error("address latch not three cycles");
  a_ale_drives_addr: assert property (pins.ale |-> pins.ad_oe && pins.rd_n && pins.wr_n)
    else $error("address phase not driving bus");
  a_tristate_quiet: assert property (!pins.strobe_oe |-> !pins.ad_oe && !pins.ale)
    else $error("pins driven while three-stated");
  a_read_releases: assert property (!pins.rd_n |-> pins.wr_n && !pins.ad_oe)
    else $error("bus driven during read strobe");
  a_write_drives: assert property (!pins.wr_n |-> pins.ad_oe && pins.rd_n)
    else $error("write strobe without data");
  a_rvalid_follows: assert property (1'b1 |=> iop_rvalid == $past(iop_req.rd))
    else $error("read answer not one cycle after read");
  a_mem_req_holds: assert property (mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req))
    else $error("memory request changed before ack");
  a_mem_req_drops: assert property (mem_ack |=> !mem_req.req)
    else $error("memory request held after ack");
  a_irq_one_pulse: assert property (dma_irq |=> !dma_irq)
    else $error("interrupt longer than one cycle");
endmodule // pp_dma_checker
bind pp_dma pp_dma_checker pp_dma_checker_i (.sys_clk(sys_clk), .reset_n(reset_n),
  .iop_req(iop_req), .iop_rvalid(iop_rvalid), .mem_req(mem_req), .mem_ack(mem_ack),
  .pins(pins), .dma_irq(dma_irq));
`default_nettype wire

/* verif/ext_mem.sv */
// Behavioural external memory on the parallel port pins
`timescale 1ns/1ps
`default_nettype none
module ext_mem (
  input  wire logic              sys_clk,
  input  wire pp_dma_pkg::pins_t pins,
  output logic [15:0]            ad_in
);
  import pp_dma_pkg::*;
  logic [15:0] q [$];
  logic [15:0] wv = '0;
  logic [15:0] last = '0;
  logic        wl = 0;
  logic        drv = 0;
  int          k = 0;
  // Released bus toggles so a stale sample never matches
  assign ad_in = (!pins.rd_n || drv) ? (k[0] ? 16'hC3B2 : 16'h5A01) : ~last;
  always @(posedge sys_clk) begin
    last <= ad_in;
    drv <= pins.strobe_oe && !pins.rd_n;
    if (pins.rd_n && drv) k <= k + 1;
    if (pins.strobe_oe && !pins.wr_n) begin
      wv <= pins.ad_out;
      wl <= 1;
    end else if (wl) begin
      q.push_back(wv);
      wl <= 0;
    end
  end
endmodule // ext_mem
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the port DMA block
`timescale 1ns/1ps
`default_nettype none
`include "pp_dma_params.svh"
module tb_top;
  import pp_dma_pkg::*;
  logic        sys_clk = 0;
  logic        reset_n = 0;
  logic        boot_user_mode = 1;
  iop_req_t    iop_req = '0;
  logic [31:0] iop_rdata;
  logic        iop_rvalid;
  mem_req_t    mem_req;
  logic        mem_ack = 0;
  logic [31:0] mem [64];
  pins_t       pins;
  logic [15:0] ad_in;
  logic        dma_irq;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          n_irq = 0;
  logic [31:0] rx_exp;
  logic [15:0] ofs [9] = '{`OFS_EXTERNAL_INDEX, `OFS_EXTERNAL_MODIFIER, `OFS_EXTERNAL_COUNT,
    `OFS_INTERNAL_INDEX, `OFS_INTERNAL_MODIFIER, `OFS_INTERNAL_COUNT, `OFS_CHAIN_POINTER,
    `OFS_RECEIVE_BUFFER, 16'h1850};
  logic [31:0] msk [9] = '{32'hFFFFFF, 32'h3, 32'hFFFFFF, 32'h7FFFF, 32'hFFFF, 32'hFFFF,
    32'hFFFFF, 32'h0, 32'h0};
  logic [31:0] dv [7] = '{32'h0, 32'h1, 32'h2, 32'h10, 32'h1, 32'h1, 32'h80020};
  logic [31:0] tcb [7] = '{32'h11, 32'h1, 32'h1, 32'h0, 32'h100, 32'h1, 32'h2};
  always #5 sys_clk = ~sys_clk;
  pp_dma pp_dma_i (.sys_clk(sys_clk), .reset_n(reset_n), .boot_user_mode(boot_user_mode),
    .iop_req(iop_req), .iop_rdata(iop_rdata), .iop_rvalid(iop_rvalid), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem[mem_req.addr[5:0]]), .pins(pins), .ad_in(ad_in),
    .dma_irq(dma_irq));
  ext_mem ext_mem_i (.sys_clk(sys_clk), .pins(pins), .ad_in(ad_in));
  // *****
  // Internal memory: answers every request on the next edge
  // *****
  always @(posedge sys_clk) begin
    mem_ack <= #1 mem_req.req && !mem_ack;
    if (mem_ack && mem_req.we) mem[mem_req.addr[5:0]] <= mem_req.wdata;
    if (dma_irq) n_irq <= n_irq + 1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, exp, input string nm);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic to(input logic ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wait expired");
      results();
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    iop_req.wr = 1;
    iop_req.addr = a;
    iop_req.wdata = d;
    step(1);
    iop_req.wr = 0;
    step(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] m, exp, input string nm);
    iop_req.rd = 1;
    iop_req.addr = a;
    step(1);
    iop_req.rd = 0;
    cmp(iop_rdata & m, exp, nm);
    step(1);
  endtask
  task automatic rst(input logic mode);
    reset_n = 0;
    boot_user_mode = mode;
    step(6);
    reset_n = 1;
    step(2);
  endtask
  task automatic txw(input logic [31:0] ctl, w, input int n);
    wr(`OFS_PORT_CONTROL, ctl);
    wr(`OFS_TRANSMIT_BUFFER, w);
    for (int i = 0; i < 100 && pins.ale !== 1'b1; i++) step(1);
    to(pins.ale);
    rd(`OFS_PORT_CONTROL, 32'h20000, 32'h20000, "busy during word");
    for (int i = 0; i < 300 && ext_mem_i.q.size() < n; i++) step(1);
    to(ext_mem_i.q.size() == n);
    for (int k = 0; k < n; k++)
      cmp(ext_mem_i.q.pop_front(), w >> (32 / n * k) & (n == 2 ? 32'hFFFF : 32'hFF), "unit");
    step(2);
    rd(`OFS_PORT_CONTROL, 32'h20000, 32'h0, "busy after word");
  endtask
  initial begin
    rst(1);
    rd(`OFS_PORT_CONTROL, '1, 32'h2E, "control user boot");
    rst(0);
    rd(`OFS_PORT_CONTROL, '1, 32'h0, "control other boot");
    $display("test reset done");
    foreach (ofs[i]) begin
      wr(ofs[i], '1);
      rd(ofs[i], '1, msk[i], "register width");
    end
    $display("test registers done");
    wr(`OFS_PORT_CONTROL, 32'h80000285);
    cmp({31'h0, pins.strobe_oe}, 32'h0, "strobe enable");
    txw(32'h285, 32'h89ABCDEF, 2);
    txw(32'h205, 32'h44332211, 4);
    $display("test transmit done");
    wr(`OFS_PORT_CONTROL, 32'h85);
    rd(`OFS_RECEIVE_BUFFER, '1, 32'h0, "empty receive");
    for (int i = 0; i < 200 && ext_mem_i.k < 2; i++) step(1);
    to(ext_mem_i.k == 2);
    step(3);
    rd(`OFS_PORT_STATUS, 32'h3, 32'h1, "receive status");
    rd(`OFS_RECEIVE_BUFFER, '1, 32'hC3B25A01, "received word");
    wr(`OFS_PORT_CONTROL, 32'h0);
    rd(`OFS_PORT_STATUS, 32'h3, 32'h0, "status after disable");
    $display("test receive done");
    mem[16] = 32'h11112222;
    mem[17] = 32'h33334444;
    foreach (tcb[i]) mem[32 + i] = tcb[i];
    for (int i = 0; i < 7; i++) wr(ofs[i], dv[i]);
    wr(`OFS_PORT_CONTROL, 32'h40000385);
    for (int i = 0; i < 2000 && (n_irq < 2 || ext_mem_i.q.size() < 4); i++) step(1);
    to(n_irq == 2);
    foreach (dv[i]) if (i < 4) cmp(ext_mem_i.q.pop_front(), 32'h1111 * (i ^ 1) + 32'h1111, "dma unit");
    cmp(n_irq, 2, "interrupts");
    rd(`OFS_PORT_CONTROL, 32'h40000, 32'h0, "chain load idle");
    rd(`OFS_EXTERNAL_INDEX, '1, 32'h102, "external index");
    rd(`OFS_INTERNAL_INDEX, '1, 32'h12, "internal index");
    rd(`OFS_INTERNAL_COUNT, '1, 32'h0, "internal count");
    $display("test chain done");
    wr(`OFS_PORT_CONTROL, 32'h0);
    wr(ofs[2], 32'h2);
    wr(ofs[3], 32'h28);
    wr(ofs[5], 32'h1);
    rx_exp = ext_mem_i.k[0] ? 32'h5A01C3B2 : 32'hC3B25A01;
    wr(`OFS_PORT_CONTROL, 32'h185);
    for (int i = 0; i < 500 && n_irq < 3; i++) step(1);
    to(n_irq == 3);
    cmp(mem[40], rx_exp, "dma receive word");
    rd(`OFS_EXTERNAL_COUNT, '1, 32'h0, "external count");
    $display("test receive dma done");
    results();
  end
endmodule // tb_top
`default_nettype wire
